/* File: core/dsp_port.v */
`include "dsp_port_regs.vh"
`timescale 1ns/100ps
`default_nettype none
// Two-beat DDR separate-I/O SRAM port modelled at the system clock: one
// system cycle is one input clock period, beat A is the rising input clock
// half, beat B the rising inverted half. Data pins run at half DDR rate.
module dsp_port #(
  parameter AW = 10,
  parameter LW = 9,
  parameter NL = 2,
  parameter LOCK_CYCLES = `DSP_DLL_LOCK_CYCLES
) (
  input wire I_SYS_CLK,
  input wire I_RST_N,
  input wire I_READ_SEL_N,
  input wire I_WRITE_SEL_N,
  input wire [AW-1:0] I_RD_ADDR_IN,
  input wire [AW-1:0] I_WR_ADDR_IN,
  input wire [NL*LW-1:0] I_WR_DATA_IN,
  input wire [NL-1:0] I_BYTE_MASK_N,
  input wire I_OUT_CLK_TIED_HIGH,
  input wire I_DLL_DISABLE_N,
  input wire I_IN_CLK_RUNNING,
  output reg [NL*LW-1:0] O_RD_DATA_OUT,
  output reg O_RD_DATA_OE,
  output reg O_RD_BEAT2,
  output reg O_OUT_CLK_FROM_IN,
  output reg O_DLL_LOCKED
);
  localparam DW = NL*LW;
  localparam MA = AW + 1;
  localparam STOP_W = 4;
  localparam integer STOP_CYC_I = `DSP_CLK_STOP_CYCLES;
  localparam [STOP_W-1:0] STOP_CYC = STOP_CYC_I[STOP_W-1:0];
  localparam CW = 16;
  localparam integer LOCK_CYC_I = LOCK_CYCLES;
  localparam [CW-1:0] LOCK_CYC = LOCK_CYC_I[CW-1:0];
  localparam [2:0] RD_IDLE = 3'h1;
  localparam [2:0] RD_B1 = 3'h2;
  localparam [2:0] RD_B2 = 3'h4;
  localparam [2:0] WR_IDLE = 3'h1;
  localparam [2:0] WR_B1 = 3'h2;
  localparam [2:0] WR_B2 = 3'h4;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [4:0] s1_reg;
  reg [4:0] s2_reg;
  reg [AW-1:0] ra1_reg, ra2_reg, wa1_reg, wa2_reg;
  reg [DW-1:0] wd1_reg, wd2_reg;
  reg [NL-1:0] bm1_reg, bm2_reg;
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      // Idle pin levels, so no false command or clock-source flip follows reset
      s1_reg <= 5'h13;
      s2_reg <= 5'h13;
      ra1_reg <= {AW{1'b0}};
      ra2_reg <= {AW{1'b0}};
      wa1_reg <= {AW{1'b0}};
      wa2_reg <= {AW{1'b0}};
      wd1_reg <= {DW{1'b0}};
      wd2_reg <= {DW{1'b0}};
      bm1_reg <= {NL{1'b1}};
      bm2_reg <= {NL{1'b1}};
    end else begin
      // All pins registered on edges, never used as levels
      s1_reg <= {I_IN_CLK_RUNNING, I_DLL_DISABLE_N, I_OUT_CLK_TIED_HIGH,
                 I_WRITE_SEL_N, I_READ_SEL_N};
      s2_reg <= s1_reg;
      ra1_reg <= I_RD_ADDR_IN;
      ra2_reg <= ra1_reg;
      wa1_reg <= I_WR_ADDR_IN;
      wa2_reg <= wa1_reg;
      wd1_reg <= I_WR_DATA_IN;
      wd2_reg <= wd1_reg;
      bm1_reg <= I_BYTE_MASK_N;
      bm2_reg <= bm1_reg;
    end
  end
  wire rd_sel_n = s2_reg[0];
  wire wr_sel_n = s2_reg[1];
  wire out_tied = s2_reg[2];
  wire dll_en = s2_reg[3];
  wire clk_run = s2_reg[4];

  function [MA-1:0] beat_addr;
    input [AW-1:0] base;
    input beat;
    beat_addr = {base, beat};
  endfunction

  // Active-low lane masks become lane write enables
  function [NL-1:0] lane_en;
    input [NL-1:0] mask_n;
    lane_en = ~mask_n;
  endfunction

  // ****************************************
  // Read and write state machines
  // ****************************************
  // Independent machines; neither reads the other's state
  reg [2:0] rd_st_reg, rd_st_next;
  reg [2:0] wr_st_reg, wr_st_next;
  reg [AW-1:0] rd_base_reg, rd_base_next;
  reg [AW-1:0] wr_base_reg, wr_base_next;
  reg [DW-1:0] wr_d2_reg, wr_d2_next;
  reg [NL-1:0] wr_m2_reg, wr_m2_next;
  reg mem_we;
  reg [MA-1:0] mem_waddr;
  reg [DW-1:0] mem_wdata;
  reg [NL-1:0] mem_lane_we;
  reg [MA-1:0] mem_raddr;

  always @* begin
    rd_st_next = rd_st_reg;
    rd_base_next = rd_base_reg;
    mem_raddr = beat_addr(rd_base_reg, 1'b0);
    case (rd_st_reg)
      RD_IDLE, RD_B2: begin
        // Low select starts a read; high is a deselect
        if (!rd_sel_n) begin
          rd_st_next = RD_B1;
          rd_base_next = ra2_reg;
        end else begin
          rd_st_next = RD_IDLE;
        end
        mem_raddr = beat_addr(ra2_reg, 1'b0);
      end
      RD_B1: begin
        // Second beat never skipped
        rd_st_next = RD_B2;
        mem_raddr = beat_addr(rd_base_reg, 1'b1);
      end
      default: begin
        rd_st_next = RD_IDLE;
      end
    endcase
  end

  always @* begin
    wr_st_next = wr_st_reg;
    wr_base_next = wr_base_reg;
    wr_d2_next = wr_d2_reg;
    wr_m2_next = wr_m2_reg;
    mem_we = 1'b0;
    mem_waddr = beat_addr(wr_base_reg, 1'b0);
    mem_wdata = wd2_reg;
    mem_lane_we = lane_en(bm2_reg);
    case (wr_st_reg)
      WR_IDLE, WR_B2: begin
        // Command with beat one and its mask
        if (!wr_sel_n) begin
          wr_st_next = WR_B1;
          wr_d2_next = wd2_reg;
          wr_m2_next = bm2_reg;
        end else begin
          wr_st_next = WR_IDLE;
        end
      end
      WR_B1: begin
        // Address arrives with beat two; beat one stored now, beat two next cycle
        wr_st_next = WR_B2;
        wr_base_next = wa2_reg;
        mem_we = 1'b1;
        mem_waddr = beat_addr(wa2_reg, 1'b0);
        mem_wdata = wr_d2_reg;
        mem_lane_we = lane_en(wr_m2_reg);
      end
      default: begin
        wr_st_next = WR_IDLE;
      end
    endcase
  end

  // Beat two goes to the memory one cycle after beat one
  reg wr_b2_pend_reg;
  reg [DW-1:0] wr_b2_data_reg;
  reg [NL-1:0] wr_b2_mask_reg;
  reg [MA-1:0] wr_b2_addr_reg;
  reg b1_we;
  reg [MA-1:0] b_waddr;
  reg [DW-1:0] b_wdata;
  reg [NL-1:0] b_lane;
  always @* begin
    b1_we = mem_we | wr_b2_pend_reg;
    b_waddr = mem_we ? mem_waddr : wr_b2_addr_reg;
    b_wdata = mem_we ? mem_wdata : wr_b2_data_reg;
    b_lane = mem_we ? mem_lane_we : wr_b2_mask_reg;
  end

  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rd_st_reg <= RD_IDLE;
      wr_st_reg <= WR_IDLE;
      rd_base_reg <= {AW{1'b0}};
      wr_base_reg <= {AW{1'b0}};
      wr_d2_reg <= {DW{1'b0}};
      wr_m2_reg <= {NL{1'b1}};
      wr_b2_pend_reg <= 1'b0;
      wr_b2_data_reg <= {DW{1'b0}};
      wr_b2_mask_reg <= {NL{1'b0}};
      wr_b2_addr_reg <= {MA{1'b0}};
    end else begin
      rd_st_reg <= rd_st_next;
      wr_st_reg <= wr_st_next;
      rd_base_reg <= rd_base_next;
      wr_base_reg <= wr_base_next;
      wr_d2_reg <= wr_d2_next;
      wr_m2_reg <= wr_m2_next;
      // Beat two uses its own mask captured this cycle
      wr_b2_pend_reg <= mem_we;
      wr_b2_data_reg <= wd2_reg;
      wr_b2_mask_reg <= lane_en(bm2_reg);
      wr_b2_addr_reg <= beat_addr(wa2_reg, 1'b1);
    end
  end

  wire [DW-1:0] mem_rdata;
  dsp_mem #(
    .AW(MA),
    .DW(DW),
    .LW(LW),
    .NL(NL)
  ) u_mem (
    .i_clk(I_SYS_CLK),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata),
    .i_we(b1_we),
    .i_waddr(b_waddr),
    .i_wdata(b_wdata),
    .i_lane_we(b_lane)
  );

  // ****************************************
  // Coherency bypass
  // ****************************************
  // Memory read lags the write by a cycle; a matching address and lane
  // write in that cycle is forwarded so reads see newest data
  reg byp_hit_reg;
  reg [DW-1:0] byp_data_reg;
  reg [NL-1:0] byp_lane_reg;
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      byp_hit_reg <= 1'b0;
      byp_data_reg <= {DW{1'b0}};
      byp_lane_reg <= {NL{1'b0}};
    end else begin
      byp_hit_reg <= b1_we && (b_waddr == mem_raddr);
      byp_data_reg <= b_wdata;
      byp_lane_reg <= b_lane;
    end
  end

  // ****************************************
  // Same-cycle write forwarding
  // ****************************************
  // A write sharing the read's cycle lands in the array one cycle after
  // each array read, so both beats are patched from the write in flight
  function [DW-1:0] lane_merge;
    input [DW-1:0] old_word;
    input [DW-1:0] new_word;
    input [NL-1:0] lane_on;
    integer n;
    begin
      lane_merge = old_word;
      for (n = 0; n < NL; n = n + 1) begin
        if (lane_on[n]) begin
          lane_merge[n*LW +: LW] = new_word[n*LW +: LW];
        end
      end
    end
  endfunction

  wire fwd_b1 = (rd_st_reg == RD_B1) && mem_we &&
                (mem_waddr == beat_addr(rd_base_reg, 1'b0));
  wire fwd_b2 = (rd_st_reg == RD_B2) && wr_b2_pend_reg &&
                (wr_b2_addr_reg == beat_addr(rd_base_reg, 1'b1));
  reg [DW-1:0] byp_word;
  reg [DW-1:0] rd_word;
  always @* begin
    byp_word = lane_merge(mem_rdata, byp_data_reg, byp_lane_reg & {NL{byp_hit_reg}});
    rd_word = byp_word;
    if (fwd_b1) begin
      rd_word = lane_merge(byp_word, mem_wdata, mem_lane_we);
    end else if (fwd_b2) begin
      rd_word = lane_merge(byp_word, wr_b2_data_reg, wr_b2_mask_reg);
    end
  end

  // ****************************************
  // Output registers and clock source
  // ****************************************
  // Beat one after the next input edge, beat two one cycle on
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RD_DATA_OUT <= {DW{1'b0}};
      O_RD_DATA_OE <= 1'b0;
      O_RD_BEAT2 <= 1'b0;
      O_OUT_CLK_FROM_IN <= 1'b0;
    end else begin
      // Idle data reads as zero where the pins would float
      O_RD_DATA_OUT <= ((rd_st_reg == RD_B1) || (rd_st_reg == RD_B2)) ? rd_word : {DW{1'b0}};
      O_RD_DATA_OE <= (rd_st_reg == RD_B1) || (rd_st_reg == RD_B2);
      O_RD_BEAT2 <= (rd_st_reg == RD_B2);
      // Tied-high output clocks hand firing to input clocks
      O_OUT_CLK_FROM_IN <= out_tied;
    end
  end

  // ****************************************
  // DLL lock timer
  // ****************************************
  // Locks to the input clock whatever source is chosen above; the phase loop itself is analogue and
  // only its lock timing is modelled here
  reg [CW-1:0] lock_cnt_reg;
  reg [STOP_W-1:0] stop_cnt_reg;
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      lock_cnt_reg <= {CW{1'b0}};
      stop_cnt_reg <= {STOP_W{1'b0}};
      O_DLL_LOCKED <= 1'b0;
    end else begin
      stop_cnt_reg <= clk_run ? {STOP_W{1'b0}} :
                      (stop_cnt_reg == STOP_CYC) ? stop_cnt_reg : stop_cnt_reg + 4'h1;
      // Disable low or a long clock stop resets; relock counts again
      if (!dll_en || (!clk_run && (stop_cnt_reg + 4'h1 >= STOP_CYC))) begin
        lock_cnt_reg <= {CW{1'b0}};
        O_DLL_LOCKED <= 1'b0;
      end else if (clk_run && lock_cnt_reg != LOCK_CYC) begin
        lock_cnt_reg <= lock_cnt_reg + 16'h0001;
        O_DLL_LOCKED <= (lock_cnt_reg + 16'h0001 == LOCK_CYC);
      end
    end
  end
endmodule
`default_nettype wire

/* File: core/dsp_port_regs.vh */
`ifndef DSP_PORT_REGS_VH
`define DSP_PORT_REGS_VH
`define DSP_CLK_PERIOD_NS 40
`define DSP_DLL_LOCK_CYCLES 1024
`define DSP_CLK_STOP_NS 30
`define DSP_CLK_STOP_CYCLES ((`DSP_CLK_STOP_NS + `DSP_CLK_PERIOD_NS - 1) / `DSP_CLK_PERIOD_NS)
`define DSP_BYTE_LANE_W 9
`define DSP_NIBBLE_LANE_W 4
`endif

/* File: core/dsp_mem.v */
`timescale 1ns/100ps
`default_nettype none
module dsp_mem #(
  parameter AW = 11,
  parameter DW = 18,
  parameter LW = 9,
  parameter NL = 2
) (
  input wire i_clk,
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  input wire [NL-1:0] i_lane_we
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer k;
  // ****************************************
  // Lane-masked write, registered read
  // ****************************************
  always @(posedge i_clk) begin
    if (i_we) begin
      for (k = 0; k < NL; k = k + 1) begin
        if (i_lane_we[k]) begin
          mem[i_waddr][k*LW +: LW] <= i_wdata[k*LW +: LW];
        end
      end
    end
    o_rdata <= mem[i_raddr];
  end
endmodule
`default_nettype wire

/* File: verif/dsp_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ********************************
// Controller model
// ********************************
// Unused address lines show the inverse of their last value, never stale data; data lines carry d0 then d1
module dsp_ctrl_model #(
  parameter AW = 10,
  parameter LW = 9
) (
  input wire logic clk,
  output logic o_read_sel_n,
  output logic o_write_sel_n,
  output logic [AW-1:0] o_rd_addr,
  output logic [AW-1:0] o_wr_addr,
  output logic [2*LW-1:0] o_wr_data,
  output logic [1:0] o_mask_n
);
  logic [2*LW-1:0] shadow [0:(2**(AW+1))-1];
  logic [2*LW:0] exp_q [$];
  initial begin
    o_read_sel_n = 1'b1;
    o_write_sel_n = 1'b1;
    o_rd_addr = '0;
    o_wr_addr = '0;
    o_wr_data = '0;
    o_mask_n = 2'h3;
  end
  task automatic slot(input logic rd, input logic wr, input logic [AW-1:0] ra,
    input logic [AW-1:0] wa, input logic [2*LW-1:0] d0, input logic [2*LW-1:0] d1,
    input logic [1:0] m0, input logic [1:0] m1);
    begin
      if (wr) begin
        for (int k = 0; k < 2; k++) begin
          if (!m0[k]) shadow[{wa, 1'b0}][k*LW +: LW] = d0[k*LW +: LW];
          if (!m1[k]) shadow[{wa, 1'b1}][k*LW +: LW] = d1[k*LW +: LW];
        end
      end
      if (rd) begin
        exp_q.push_back({1'b0, shadow[{ra, 1'b0}]});
        exp_q.push_back({1'b1, shadow[{ra, 1'b1}]});
      end
      o_read_sel_n <= !rd;
      o_write_sel_n <= !wr;
      o_rd_addr <= ra;
      o_wr_addr <= ~o_wr_addr;
      o_wr_data <= d0;
      o_mask_n <= m0;
      @(posedge clk);
      o_read_sel_n <= 1'b1;
      o_write_sel_n <= 1'b1;
      o_rd_addr <= ~ra;
      o_wr_addr <= wa;
      o_wr_data <= d1;
      o_mask_n <= m1;
      @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/dsp_port_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// ********************************
// Port checker
// ********************************
module dsp_port_asserts #(
  parameter AW = 10,
  parameter LW = 9,
  parameter NL = 2,
  parameter LOCK_CYCLES = 16
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_READ_SEL_N,
  input wire logic I_OUT_CLK_TIED_HIGH,
  input wire logic I_DLL_DISABLE_N,
  input wire logic I_IN_CLK_RUNNING,
  input wire logic O_RD_DATA_OE,
  input wire logic O_RD_BEAT2,
  input wire logic O_OUT_CLK_FROM_IN,
  input wire logic O_DLL_LOCKED
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  // Clean enabled cycles; saturates so a long run never wraps to a false early lock
  logic [15:0] run_cnt_reg;
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      run_cnt_reg <= 16'h0000;
    end else if (!I_DLL_DISABLE_N || !I_IN_CLK_RUNNING) begin
      run_cnt_reg <= 16'h0000;
    end else if (run_cnt_reg != 16'hFFFF) begin
      run_cnt_reg <= run_cnt_reg + 16'h0001;
    end
  end
  rd_latency_a: assert property (!I_READ_SEL_N |-> ##4 (O_RD_DATA_OE && !O_RD_BEAT2))
    else $error("read beat one late or missing");
  rd_deselect_a: assert property ((O_RD_DATA_OE && !O_RD_BEAT2) |-> $past(!I_READ_SEL_N, 4))
    else $error("read data without read command");
  beat_pair_a: assert property ($rose(O_RD_DATA_OE) |=> O_RD_DATA_OE && O_RD_BEAT2)
    else $error("second read beat missing");
  beat2_origin_a: assert property (O_RD_BEAT2 |-> O_RD_DATA_OE && $past(O_RD_DATA_OE && !O_RD_BEAT2))
    else $error("second beat without first");
  beat2_single_a: assert property (O_RD_BEAT2 |=> !O_RD_BEAT2)
    else $error("second beat held too long");
  out_clk_src_a: assert property ($stable(I_OUT_CLK_TIED_HIGH) [*5] |-> O_OUT_CLK_FROM_IN == I_OUT_CLK_TIED_HIGH)
    else $error("output clock source wrong");
  dll_off_drop_a: assert property (!I_DLL_DISABLE_N |-> ##[1:4] !O_DLL_LOCKED)
    else $error("lock kept with dll disabled");
  clk_stop_drop_a: assert property (!I_IN_CLK_RUNNING |-> ##[1:4] !O_DLL_LOCKED)
    else $error("lock kept with clock stopped");
  lock_wait_a: assert property ($rose(O_DLL_LOCKED) |-> run_cnt_reg >= LOCK_CYCLES)
    else $error("lock reported too early");
endmodule
bind dsp_port dsp_port_asserts #(.AW(AW), .LW(LW), .NL(NL), .LOCK_CYCLES(LOCK_CYCLES)) u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_READ_SEL_N(I_READ_SEL_N),
  .I_OUT_CLK_TIED_HIGH(I_OUT_CLK_TIED_HIGH), .I_DLL_DISABLE_N(I_DLL_DISABLE_N),
  .I_IN_CLK_RUNNING(I_IN_CLK_RUNNING), .O_RD_DATA_OE(O_RD_DATA_OE), .O_RD_BEAT2(O_RD_BEAT2),
  .O_OUT_CLK_FROM_IN(O_OUT_CLK_FROM_IN), .O_DLL_LOCKED(O_DLL_LOCKED)
);
`default_nettype wire

/* File: verif/tb_ddr_separate_io_sram_port.sv */
`timescale 1ns/100ps
`default_nettype none
// ********************************
// Testbench
// ********************************
module tb_ddr_separate_io_sram_port;
  localparam int LOCK = 16;
  logic clk = 1'b0;
  logic rst_n, tied, dll_n, running, rs_n, ws_n, oe, beat2, from_in, locked;
  logic [9:0] ra, wa;
  logic [17:0] wd, rdat;
  logic [1:0] mk;
  logic [18:0] exp_v;
  logic [31:0] r = 32'hAE4A7800;
  int error_cnt = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  dsp_ctrl_model u_ctrl (.clk(clk), .o_read_sel_n(rs_n), .o_write_sel_n(ws_n),
    .o_rd_addr(ra), .o_wr_addr(wa), .o_wr_data(wd), .o_mask_n(mk));
  dsp_port #(.LOCK_CYCLES(LOCK)) u_dut (.I_SYS_CLK(clk), .I_RST_N(rst_n),
    .I_READ_SEL_N(rs_n), .I_WRITE_SEL_N(ws_n), .I_RD_ADDR_IN(ra), .I_WR_ADDR_IN(wa),
    .I_WR_DATA_IN(wd), .I_BYTE_MASK_N(mk), .I_OUT_CLK_TIED_HIGH(tied),
    .I_DLL_DISABLE_N(dll_n), .I_IN_CLK_RUNNING(running), .O_RD_DATA_OUT(rdat),
    .O_RD_DATA_OE(oe), .O_RD_BEAT2(beat2), .O_OUT_CLK_FROM_IN(from_in), .O_DLL_LOCKED(locked));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [18:0] seen, input logic [18:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("error_cnt=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_lock();
    int n;
    n = 0;
    while (locked !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("dll_lock", {18'h0, locked}, 19'h00001);
    if (locked !== 1'b1) final_report();
    @(posedge clk);
  endtask
  // Each read beat is matched against the oldest noted expectation
  always @(negedge clk) begin
    if (oe === 1'b1) begin
      exp_v = u_ctrl.exp_q.pop_front();
      check("rd_beat", {beat2, rdat}, exp_v);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    tied = 1'b0;
    dll_n = 1'b0;
    running = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    dll_n <= 1'b1;
    repeat (LOCK - 4) @(posedge clk);
    @(negedge clk);
    check("dll_early", {18'h0, locked}, 19'h0);
    wait_lock();
    for (int i = 0; i < 8; i++) begin
      r = nx(r);
      u_ctrl.slot(1'b0, 1'b1, 10'h000, 10'(i), r[17:0], r[31:14], 2'h0, 2'h0);
    end
    // Masked writes race reads of older data on the other port
    for (int i = 0; i < 8; i++) begin
      r = nx(r);
      u_ctrl.slot(1'b1, 1'b1, 10'((i + 4) % 8), 10'(i), r[17:0], r[31:14], r[1:0], r[3:2]);
    end
    r = nx(r);
    u_ctrl.slot(1'b0, 1'b0, r[9:0], 10'h003, r[17:0], r[31:14], 2'h0, 2'h0);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      r = nx(r);
      u_ctrl.slot(1'b1, 1'(i % 2), 10'(i), 10'(i), r[17:0], r[31:14], r[1:0], r[3:2]);
    end
    repeat (10) @(posedge clk);
    check("rd_left", 19'(u_ctrl.exp_q.size()), 19'h0);
    tied <= 1'b1;
    repeat (6) @(posedge clk);
    check("clk_src", {18'h0, from_in}, 19'h00001);
    tied <= 1'b0;
    running <= 1'b0;
    repeat (5) @(posedge clk);
    check("clk_stop", {18'h0, locked}, 19'h0);
    running <= 1'b1;
    wait_lock();
    dll_n <= 1'b0;
    repeat (5) @(posedge clk);
    check("dll_off", {18'h0, locked}, 19'h0);
    dll_n <= 1'b1;
    wait_lock();
    final_report();
  end
endmodule
`default_nettype wire
